/* File: design/scfg_pkg.sv */
// Constants shared by the step-3 routing and calibration configuration bank
// Summary of operation
// - Route code: 00 none, 01-11 modulators 0-2
// - Low route register resets diodes 3..0 to 00,10,01,00
// - High route: diode5 bits3:2, diode4 bits1:0
// - Repeat rate: 00 never, nth, FF once
// - Count rounds or steps per step-enable
// - Bit 7 enables residual calibration on nth
// - Residual calibration only in first step
// - Bit 6 enables auto-zero calibration on nth
// - Bit 4: recalibrate after gain change
package scfg_pkg;
  localparam logic [7:0] ROUTE_LOW_ADDR   = 8'hE2;
  localparam logic [7:0] ROUTE_HIGH_ADDR  = 8'hE3;
  localparam logic [7:0] REPEAT_ADDR      = 8'hE4;
  localparam logic [7:0] CAL_FLAGS_ADDR   = 8'hE6;

  localparam logic [7:0] ROUTE_LOW_RESET  = 8'h24;
  localparam logic [3:0] ROUTE_HIGH_RESET = 4'h3;
  localparam logic [7:0] REPEAT_RESET     = 8'hFF;
  localparam logic [3:0] CAL_FLAGS_RESET  = 4'hD;
  localparam logic [3:0] CAL_FLAGS_RSVD   = 4'h3;

  localparam logic [7:0] REPEAT_NEVER     = 8'h00;
  localparam logic [7:0] REPEAT_ONCE      = 8'hFF;

  localparam int RESIDUAL_BIT  = 7;
  localparam int AUTOZERO_BIT  = 6;
  localparam int AGC_BIT       = 5;
  localparam int GAIN_RECAL_BIT = 4;

  localparam int DIODES     = 6;
  localparam int MODULATORS = 3;
  localparam logic [1:0] ROUTE_NONE = 2'h0;
endpackage

/* File: design/scfg_regs.sv */
// Step-3 diode routing and modulator calibration scheduling register bank
module scfg_regs
  import scfg_pkg::*;
(
  input  wire logic                  ref_clk,
  input  wire logic                  rst_n,
  input  wire logic [7:0]            reg_addr,
  input  wire logic                  reg_wr,
  input  wire logic [7:0]            reg_wdata,
  input  wire logic                  reg_rd,
  output logic      [7:0]            reg_rdata,
  input  wire logic                  meas_start,
  input  wire logic                  round_start,
  input  wire logic                  step_start,
  input  wire logic                  first_step,
  input  wire logic                  step_enable,
  input  wire logic                  gain_changed,
  output logic      [DIODES-1:0]     mod_diodes [MODULATORS],
  output logic                       calib_due,
  output logic                       residual_cal,
  output logic                       autozero_cal,
  output logic                       agc_cal,
  output logic                       gain_recal
);

  logic [7:0] route_low;
  logic [3:0] route_high;
  logic [7:0] repeat_rate;
  logic [3:0] cal_flags;
  logic [7:0] iter_cnt;
  logic       once_done;
  logic       gain_pending;
  logic       count_event;
  logic       next_due;
  logic [2*DIODES-1:0] route_all;

  // All checks below sample on the register clock, idle during reset
  default clocking chk_cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  // Two-bit route code of one diode to the modulator it feeds
  function automatic logic route_hits(input logic [1:0] code,
                                      input int         modulator);
    return (code != ROUTE_NONE) && (int'(code) == modulator + 1);
  endfunction

  // Register writes; reserved bits are never stored
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      route_low   <= ROUTE_LOW_RESET;
      route_high  <= ROUTE_HIGH_RESET;
      repeat_rate <= REPEAT_RESET;
      cal_flags   <= CAL_FLAGS_RESET;
    end else if (reg_wr) begin
      unique case (reg_addr)
        ROUTE_LOW_ADDR:  route_low   <= reg_wdata;
        ROUTE_HIGH_ADDR: route_high  <= reg_wdata[3:0];
        REPEAT_ADDR:     repeat_rate <= reg_wdata;
        CAL_FLAGS_ADDR:  cal_flags   <= reg_wdata[7:4];
        default: ;
      endcase
    end
  end

  // Registered read data; unmapped addresses read zero
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        ROUTE_LOW_ADDR:  reg_rdata <= route_low;
        ROUTE_HIGH_ADDR: reg_rdata <= {4'h0, route_high};
        REPEAT_ADDR:     reg_rdata <= repeat_rate;
        CAL_FLAGS_ADDR:  reg_rdata <= {cal_flags, CAL_FLAGS_RSVD};
        default:         reg_rdata <= 8'h00;
      endcase
    end
  end

  assign route_all = {route_high, route_low};

  // Diode-to-modulator connection masks for step 3
  for (genvar m = 0; m < MODULATORS; m++) begin : g_mod
    for (genvar d = 0; d < DIODES; d++) begin : g_diode
      assign mod_diodes[m][d] = route_hits(route_all[2*d +: 2], m);
    end
  end

  // Iterations are rounds or single steps, chosen by step_enable
  assign count_event = step_enable ? step_start : round_start;

  always_comb begin
    next_due = 1'b0;
    if (count_event) begin
      if (repeat_rate == REPEAT_ONCE) begin
        next_due = !once_done;
      end else if (repeat_rate != REPEAT_NEVER) begin
        next_due = (iter_cnt == repeat_rate - 8'h01);
      end
    end
  end

  // Iteration counter, restarted with each measurement
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      iter_cnt  <= 8'h00;
      once_done <= 1'b0;
    end else if (meas_start) begin
      iter_cnt  <= 8'h00;
      once_done <= 1'b0;
    end else if (count_event) begin
      once_done <= 1'b1;
      iter_cnt  <= next_due ? 8'h00 : iter_cnt + 8'h01;
    end
  end

  // Calibration requests, one-cycle pulses after the counted event
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      calib_due    <= 1'b0;
      residual_cal <= 1'b0;
      autozero_cal <= 1'b0;
      agc_cal      <= 1'b0;
    end else begin
      calib_due    <= next_due;
      residual_cal <= next_due && cal_flags[RESIDUAL_BIT-4]
                      && first_step;
      autozero_cal <= next_due && cal_flags[AUTOZERO_BIT-4];
      agc_cal      <= next_due && cal_flags[AGC_BIT-4];
    end
  end

  // Gain change is held until the next step begins
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      gain_pending <= 1'b0;
      gain_recal   <= 1'b0;
    end else begin
      gain_recal <= step_start && cal_flags[GAIN_RECAL_BIT-4]
                    && (gain_pending || gain_changed);
      if (step_start) begin
        gain_pending <= 1'b0;
      end else if (gain_changed) begin
        gain_pending <= 1'b1;
      end
    end
  end

  // Checks
  route_decode_a: assert property (
    (route_all[1:0] == 2'h2) |-> (mod_diodes[1][0] && !mod_diodes[0][0]
      && !mod_diodes[2][0]))
    else $error("diode 0 code 10 not routed to modulator 1");

  route_none_a: assert property (
    (route_all[11:10] == 2'h0) |-> !(mod_diodes[0][5] || mod_diodes[1][5]
      || mod_diodes[2][5]))
    else $error("disconnected diode 5 routed");

  route_mod0_a: assert property (
    (route_all[3:2] == 2'h1) |-> (mod_diodes[0][1] && !mod_diodes[1][1]
      && !mod_diodes[2][1]))
    else $error("diode 1 code 01 not routed to modulator 0");

  route_mod2_a: assert property (
    (route_all[9:8] == 2'h3) |-> (mod_diodes[2][4] && !mod_diodes[0][4]
      && !mod_diodes[1][4]))
    else $error("diode 4 code 11 not routed to modulator 2");

  one_target_a: assert property (
    $onehot0({mod_diodes[0][3], mod_diodes[1][3], mod_diodes[2][3]}))
    else $error("diode 3 routed to more than one modulator");

  low_reset_a: assert property (
    $past(!rst_n) && !$past(reg_wr) |-> route_low == 8'h24)
    else $error("low route register reset value wrong");

  write_low_a: assert property (
    reg_wr && reg_addr == ROUTE_LOW_ADDR |=> route_low == $past(reg_wdata))
    else $error("low route register write lost");

  read_low_a: assert property (
    reg_rd && reg_addr == ROUTE_LOW_ADDR
      |=> reg_rdata == $past(route_low))
    else $error("low route register read wrong");

  high_reset_a: assert property (
    $past(!rst_n) |-> mod_diodes[2][4] && !mod_diodes[0][5])
    else $error("high route register reset routing wrong");

  high_read_a: assert property (
    reg_rd && reg_addr == ROUTE_HIGH_ADDR |=> reg_rdata[7:4] == 4'h0)
    else $error("reserved high route bits not zero");

  write_high_a: assert property (
    reg_wr && reg_addr == ROUTE_HIGH_ADDR
      |=> route_high == $past(reg_wdata[3:0]))
    else $error("high route register write lost");

  never_cal_a: assert property (
    repeat_rate == 8'h00 |=> !calib_due)
    else $error("calibration with repeat rate zero");

  never_due_a: assert property (
    repeat_rate == REPEAT_NEVER |-> !next_due)
    else $error("calibration scheduled with repeat rate zero");

  once_only_a: assert property (
    calib_due && repeat_rate == 8'hFF && !meas_start
      && $stable(repeat_rate) |=> !calib_due [*2])
    else $error("once-only calibration repeated");

  rate_one_a: assert property (
    repeat_rate == 8'h01 && count_event |-> next_due)
    else $error("rate one did not schedule every event");

  due_pulse_a: assert property (
    next_due |=> calib_due)
    else $error("scheduled calibration not requested");

  pulse_source_a: assert property (
    calib_due |-> $past(next_due))
    else $error("calibration request without schedule");

  meas_restart_a: assert property (
    meas_start |=> !once_done && iter_cnt == 8'h00)
    else $error("measurement start did not restart the count");

  write_rate_a: assert property (
    reg_wr && reg_addr == REPEAT_ADDR |=> repeat_rate == $past(reg_wdata))
    else $error("repeat rate write lost");

  read_rate_a: assert property (
    reg_rd && reg_addr == REPEAT_ADDR
      |=> reg_rdata == $past(repeat_rate))
    else $error("repeat rate read wrong");

  every_second_a: assert property (
    repeat_rate == 8'h02 && step_enable && iter_cnt == 8'h00
      && step_start && !meas_start |=> !calib_due)
    else $error("calibration on first of two steps");

  due_event_a: assert property (
    next_due |-> count_event)
    else $error("calibration scheduled without a counted event");

  round_mode_a: assert property (
    !step_enable && step_start && !round_start |-> !count_event)
    else $error("step counted in round mode");

  step_mode_a: assert property (
    step_enable && round_start && !step_start |-> !count_event)
    else $error("round counted in step mode");

  residual_gate_a: assert property (
    next_due && cal_flags[3] && first_step |=> residual_cal)
    else $error("residual calibration not requested");

  residual_off_a: assert property (
    !cal_flags[3] |=> !residual_cal)
    else $error("residual calibration while disabled");

  write_flags_a: assert property (
    reg_wr && reg_addr == CAL_FLAGS_ADDR
      |=> cal_flags == $past(reg_wdata[7:4]))
    else $error("calibration flags write lost");

  read_flags_a: assert property (
    reg_rd && reg_addr == CAL_FLAGS_ADDR
      |=> reg_rdata == {$past(cal_flags), CAL_FLAGS_RSVD})
    else $error("calibration flags read wrong");

  residual_first_a: assert property (
    residual_cal |-> calib_due && $past(first_step)
      && $past(cal_flags[3]))
    else $error("residual calibration outside first step");

  first_only_a: assert property (
    !first_step |=> !residual_cal)
    else $error("residual calibration in a later step");

  autozero_gate_a: assert property (
    next_due && cal_flags[2] |=> autozero_cal)
    else $error("auto-zero calibration not requested");

  autozero_off_a: assert property (
    !cal_flags[2] |=> !autozero_cal)
    else $error("auto-zero calibration while disabled");

  gain_recal_a: assert property (
    gain_changed && cal_flags[0] && !step_start ##1 step_start
      && $stable(cal_flags) |=> gain_recal)
    else $error("gain change did not recalibrate at step start");

  gain_off_a: assert property (
    !cal_flags[0] |=> !gain_recal)
    else $error("gain recalibration while disabled");

  gain_step_a: assert property (
    gain_recal |-> $past(step_start))
    else $error("gain recalibration outside step start");

endmodule

/* File: verification/scfg_regs_tb_top.sv */
// Self-checking bench for the step-3 routing and calibration register bank
module scfg_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import scfg_pkg::*;
  logic ref_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0;
  logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, fl = 8'hD3;
  logic meas_start = 0, round_start = 0, step_start = 0, first_step = 1;
  logic step_enable = 0, gain_changed = 0;
  logic [DIODES-1:0] mod_diodes [MODULATORS];
  logic calib_due, residual_cal, autozero_cal, agc_cal, gain_recal;
  logic [7:0] n_due, n_res, n_az, n_agc, n_gr;
  int err_total = 0, checks_done = 0;
  scfg_regs scfg_regs_inst (.ref_clk(ref_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .meas_start(meas_start),
    .round_start(round_start), .step_start(step_start),
    .first_step(first_step), .step_enable(step_enable),
    .gain_changed(gain_changed), .mod_diodes(mod_diodes),
    .calib_due(calib_due), .residual_cal(residual_cal),
    .autozero_cal(autozero_cal), .agc_cal(agc_cal),
    .gain_recal(gain_recal));
  always #5 ref_clk = ~ref_clk;
  // Pulse counters for the scheduler outputs
  always @(posedge ref_clk) begin
    if (calib_due === 1'b1) n_due <= n_due + 1;
    if (residual_cal === 1'b1) n_res <= n_res + 1;
    if (autozero_cal === 1'b1) n_az <= n_az + 1;
    if (agc_cal === 1'b1) n_agc <= n_agc + 1;
    if (gain_recal === 1'b1) n_gr <= n_gr + 1;
  end
  task automatic chk(input string nm, input logic [7:0] s, e);
    checks_done++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge ref_clk);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1;
    @(posedge ref_clk);
    reg_wr <= 0;
  endtask
  task automatic rd(input logic [7:0] a, e);
    @(posedge ref_clk);
    reg_addr <= a; reg_rd <= 1;
    @(posedge ref_clk);
    reg_rd <= 0;
    #1 chk("reg_rdata", reg_rdata, e);
  endtask
  task automatic clr();
    #1 {n_due, n_res, n_az, n_agc, n_gr} = '0;
  endtask
  task automatic routes(input logic [5:0] m0, m1, m2);
    #1 chk("mod0", {2'h0, mod_diodes[0]}, {2'h0, m0});
    chk("mod1", {2'h0, mod_diodes[1]}, {2'h0, m1});
    chk("mod2", {2'h0, mod_diodes[2]}, {2'h0, m2});
  endtask
  task automatic run(input logic [7:0] r, input logic s, input int n,
                     input logic [7:0] e);
    wr(8'hE4, r);
    step_enable <= s;
    @(posedge ref_clk) meas_start <= 1;
    @(posedge ref_clk) meas_start <= 0;
    clr();
    repeat (n) begin
      @(posedge ref_clk);
      if (s) step_start <= 1;
      else round_start <= 1;
      @(posedge ref_clk);
      step_start <= 0;
      round_start <= 0;
    end
    repeat (3) @(posedge ref_clk);
    #1 chk("calib_due", n_due, e);
    chk("residual", n_res, fl[7] && first_step ? e : 8'h00);
    chk("autozero", n_az, fl[6] ? e : 8'h00);
    chk("agc", n_agc, fl[5] ? e : 8'h00);
  endtask
  task automatic gain(input logic [7:0] f, e);
    wr(8'hE6, f);
    clr();
    @(posedge ref_clk) gain_changed <= 1;
    @(posedge ref_clk) gain_changed <= 0;
    repeat (2) @(posedge ref_clk);
    @(posedge ref_clk) step_start <= 1;
    @(posedge ref_clk) step_start <= 0;
    @(posedge ref_clk) gain_changed <= 1;
    @(posedge ref_clk) begin
      gain_changed <= 0;
      step_start <= 1;
    end
    @(posedge ref_clk) step_start <= 0;
    repeat (2) @(posedge ref_clk);
    #1 chk("gain_recal", n_gr, e);
  endtask
  initial begin
    #200000 err_total++;
    close_out();
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    rst_n <= 1;
    rd(8'hE2, 8'h24);
    rd(8'hE3, 8'h03);
    rd(8'hE4, 8'hFF);
    rd(8'hE6, 8'hD3);
    rd(8'hE5, 8'h00);
    routes(6'h02, 6'h04, 6'h10);
    wr(8'hE2, 8'hE4);
    wr(8'hE3, 8'h0F);
    rd(8'hE3, 8'h0F);
    routes(6'h02, 6'h04, 6'h38);
    wr(8'hE6, 8'h03);
    fl = 8'h03;
    rd(8'hE6, 8'h03);
    run(8'hFF, 0, 5, 1);
    wr(8'hE6, 8'hF3);
    fl = 8'hF3;
    run(8'h03, 0, 6, 2);
    wr(8'hE6, 8'hD3);
    fl = 8'hD3;
    run(8'h03, 1, 7, 2);
    @(posedge ref_clk) first_step <= 0;
    run(8'h02, 1, 4, 2);
    @(posedge ref_clk) first_step <= 1;
    wr(8'hE6, 8'hF3);
    fl = 8'hF3;
    run(8'h01, 0, 4, 4);
    run(8'hFE, 0, 4, 0);
    run(8'h00, 0, 5, 0);
    gain(8'h13, 2);
    gain(8'h03, 0);
    close_out();
  end
endmodule
